// *** inc/ocpa_pkg.sv ***
// Package of constants and types for the output coarse phase adjust stage.
package ocpa_pkg;
   localparam int OCPA_DIV_W = 32;
   localparam int OCPA_ADJ_W = 33;
   localparam logic [31:0] OCPA_MIN_HALF = 32'h0000_0002;
   localparam logic [31:0] OCPA_RST_DIV = 32'h0000_0008;
   localparam logic [31:0] OCPA_RST_DUTY = 32'h0000_0000;
   localparam logic [1:0] OCPA_SWING_410 = 2'h0;
   localparam logic [1:0] OCPA_SWING_600 = 2'h1;
   localparam logic [1:0] OCPA_SWING_750 = 2'h2;
   localparam logic [1:0] OCPA_SWING_900 = 2'h3;
   localparam logic [2:0] OCPA_SUPPLY_3V3 = 3'h0;
   localparam logic [2:0] OCPA_SUPPLY_2V5 = 3'h1;
   localparam logic [2:0] OCPA_SUPPLY_1V8 = 3'h2;
   localparam logic [2:0] OCPA_SUPPLY_1V5 = 3'h3;
   localparam logic [2:0] OCPA_SUPPLY_1V2 = 3'h4;
   typedef enum logic [1:0] {
      OCPA_ST_IDLE = 2'h0,
      OCPA_ST_LOW = 2'h1,
      OCPA_ST_HIGH = 2'h3
   } ocpa_state_t;
endpackage

// *** inc/ocpa_pad_if.sv ***
// Interface carrying one clock phase and pad settings to a buffer control.
`timescale 1ns/10ps
interface ocpa_pad_if;
   logic clk_phase;
   logic se_mode;
   logic comp_invert;
   logic out_en;
   modport core (output clk_phase, output se_mode, output comp_invert, output out_en);
   modport buf_side (input clk_phase, input se_mode, input comp_invert, input out_en);
endinterface

// *** rtl/ocpa_pad_drive.sv ***
// Pad drive logic for one output buffer: differential or two single-ended copies.
`timescale 1ns/10ps
module ocpa_pad_drive
   import ocpa_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Stage side
   ocpa_pad_if.buf_side pad,
   // Pads
   output logic true_pad,
   output logic complementary_pad,
   output logic pad_oe
);
   logic true_q, true_d, comp_q, comp_d, oe_q, oe_d;

   always_comb begin
      true_d = pad.clk_phase;
      oe_d = pad.out_en;
      // Differential always drives the complement; single-ended copies unless inverted.
      if (pad.se_mode && !pad.comp_invert) begin
         comp_d = pad.clk_phase;
      end else begin
         comp_d = ~pad.clk_phase;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         true_q <= 1'b0;
         comp_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (ce) begin
         true_q <= true_d;
         comp_q <= comp_d;
         oe_q <= oe_d;
      end
   end

   assign true_pad = true_q;
   assign complementary_pad = comp_q;
   assign pad_oe = oe_q;
endmodule // ocpa_pad_drive

// *** rtl/ocpa_stage.sv ***
// Output stage: integer divider with duty control, coarse phase shift, pad setup.
//
// Operation
// - Move output edges by whole source periods, advance or delay.
// - Shift is done by stretching or trimming high and/or low pulses.
// - Never produce fewer than two source periods high and two low.
// - One request may change the low half by up to 2^32 periods, the high half by up to 2^31.
// - Signed value, applied whole within one output period, clamped.
// - At default duty the shift is split about equally between halves.
// - With programmed high width, the whole shift goes to the low half.
// - Any number of requests accepted; cumulative range unbounded.
// - Buffer drives one differential pair or two single-ended copies.
// - Single-ended copies match, complementary pad optionally inverted.
// - Two-bit swing code selects 410, 600, 750 or 900 mV.
// - Three-bit code selects crossing point 0.9V to 2.3V in 0.2V steps.
// - Single-ended mode offers four drive impedance choices.
// - Divide by a 32-bit integer; optional high count below divider.
`timescale 1ns/10ps
module ocpa_stage
   import ocpa_pkg::*;
#(
   parameter int DIV_W = OCPA_DIV_W
)(
   // Clock and reset; mclk is the fractional divider output
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Divider configuration
   input wire logic [DIV_W-1:0] divide_ratio,
   input wire logic [DIV_W-1:0] high_count,
   input wire logic out_enable,
   // Coarse shift request
   input wire logic signed [DIV_W:0] coarse_shift_value,
   input wire logic coarse_shift_write,
   // Buffer configuration
   input wire logic se_mode,
   input wire logic comp_invert,
   input wire logic [2:0] buffer_supply_setting,
   input wire logic [1:0] differential_swing_code,
   input wire logic [2:0] crossing_point_code,
   input wire logic [1:0] impedance_code,
   // Pads and buffer settings
   output logic true_pad,
   output logic complementary_pad,
   output logic pad_oe,
   output logic [1:0] swing_sel,
   output logic [2:0] cross_sel,
   output logic [1:0] imped_sel,
   output logic [2:0] supply_sel,
   output logic diff_enable,
   // Status
   output logic shift_pending,
   output logic shift_applied
);
   // The half counters are two bits wider than the ratio, so wider ratios would overflow them.
   if (DIV_W < 3 || DIV_W > 32) begin : g_bad_width
      $error("ocpa_stage: DIV_W out of range");
   end

   localparam int CW = DIV_W + 2;

   // Clamp a signed half length to at least the minimum width.
   function automatic logic [CW-1:0] clamp_half(input logic signed [CW-1:0] v);
      logic [CW-1:0] m;
      m = CW'(OCPA_MIN_HALF);
      if (v < $signed(m)) clamp_half = m;
      else clamp_half = v;
   endfunction

   ocpa_state_t st_q, st_d;
   logic [CW-1:0] cnt_q, cnt_d, low_q, low_d;
   logic signed [DIV_W:0] pend_q, pend_d;
   logic pend_v_q, pend_v_d, clk_q, clk_d, appl_q, appl_d;
   logic [CW-1:0] base_hi, base_lo, new_hi, new_lo;
   logic signed [CW-1:0] adj_hi, adj_lo, sext;
   logic duty_prog;

   always_comb begin
      duty_prog = (high_count != '0) && (high_count < divide_ratio);
      if (duty_prog) begin
         base_hi = CW'(high_count);
         base_lo = CW'(divide_ratio) - CW'(high_count);
      end else begin
         base_hi = CW'(divide_ratio >> 1);
         base_lo = CW'(divide_ratio) - CW'(divide_ratio >> 1);
      end
      sext = pend_v_q ? CW'(pend_q) : '0;
      if (duty_prog) begin
         adj_hi = '0;
         adj_lo = sext;
      end else begin
         adj_hi = sext >>> 1;
         adj_lo = sext - (sext >>> 1);
      end
      new_hi = clamp_half($signed(base_hi) + adj_hi);
      new_lo = clamp_half($signed(base_lo) + adj_lo);
   end

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      low_d = low_q;
      clk_d = clk_q;
      pend_d = pend_q;
      pend_v_d = pend_v_q;
      appl_d = 1'b0;
      case (st_q)
         OCPA_ST_IDLE: begin
            if (out_enable) begin
               st_d = OCPA_ST_LOW;
               cnt_d = CW'(1);
            end
         end
         OCPA_ST_HIGH: begin
            if (cnt_q <= CW'(1)) begin
               st_d = OCPA_ST_LOW;
               clk_d = 1'b0;
               cnt_d = low_q;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
         OCPA_ST_LOW: begin
            if (cnt_q <= CW'(1)) begin
               if (!out_enable) begin
                  st_d = OCPA_ST_IDLE;
               end else begin
                  // Period start: whole shift lands in this one period.
                  st_d = OCPA_ST_HIGH;
                  clk_d = 1'b1;
                  cnt_d = new_hi;
                  low_d = new_lo;
                  if (pend_v_q) begin
                     pend_v_d = 1'b0;
                     appl_d = 1'b1;
                  end
               end
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
         default: begin
            st_d = OCPA_ST_IDLE;
            clk_d = 1'b0;
         end
      endcase
      // A write in the consuming cycle wins, so no request is lost.
      if (coarse_shift_write) begin
         pend_d = coarse_shift_value;
         pend_v_d = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q <= OCPA_ST_IDLE;
         cnt_q <= '0;
         low_q <= '0;
         clk_q <= 1'b0;
         pend_q <= '0;
         pend_v_q <= 1'b0;
         appl_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         low_q <= low_d;
         clk_q <= clk_d;
         pend_q <= pend_d;
         pend_v_q <= pend_v_d;
         appl_q <= appl_d;
      end
   end

   // Buffer settings are registered so pad codes change glitch free.
   logic [1:0] swing_q, imped_q;
   logic [2:0] cross_q, supply_q;
   logic diff_q;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         swing_q <= OCPA_SWING_410;
         cross_q <= 3'h0;
         imped_q <= 2'h0;
         supply_q <= OCPA_SUPPLY_3V3;
         diff_q <= 1'b0;
      end else if (ce) begin
         swing_q <= differential_swing_code;
         cross_q <= crossing_point_code;
         imped_q <= impedance_code;
         supply_q <= buffer_supply_setting;
         // Differential is refused at low supplies to protect the pad.
         diff_q <= !se_mode && (buffer_supply_setting != OCPA_SUPPLY_1V5)
            && (buffer_supply_setting != OCPA_SUPPLY_1V2);
      end
   end

   ocpa_pad_if pad_bus ();
   assign pad_bus.clk_phase = clk_q;
   assign pad_bus.se_mode = se_mode;
   assign pad_bus.comp_invert = comp_invert;
   assign pad_bus.out_en = out_enable;

   ocpa_pad_drive u_pad (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .pad(pad_bus.buf_side),
      .true_pad(true_pad),
      .complementary_pad(complementary_pad),
      .pad_oe(pad_oe)
   );

   assign swing_sel = swing_q;
   assign cross_sel = cross_q;
   assign imped_sel = imped_q;
   assign supply_sel = supply_q;
   assign diff_enable = diff_q;
   assign shift_pending = pend_v_q;
   assign shift_applied = appl_q;
endmodule // ocpa_stage

// *** test/ocpa_stage_checker.sv ***
// Concurrent checks on the ports of the output coarse phase adjust stage.
`timescale 1ns/10ps
module ocpa_stage_checker (
   // Clock, reset and controls
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic out_enable,
   input wire logic coarse_shift_write,
   input wire logic se_mode,
   input wire logic comp_invert,
   input wire logic [2:0] buffer_supply_setting,
   input wire logic [1:0] differential_swing_code,
   input wire logic [2:0] crossing_point_code,
   input wire logic [1:0] impedance_code,
   // Stage outputs
   input wire logic true_pad,
   input wire logic complementary_pad,
   input wire logic pad_oe,
   input wire logic [1:0] swing_sel,
   input wire logic [2:0] cross_sel,
   input wire logic [1:0] imped_sel,
   input wire logic diff_enable,
   input wire logic shift_pending,
   input wire logic shift_applied
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   a_swing_copy: assert property (ce |=> swing_sel == $past(differential_swing_code))
      else $error("swing code not passed");
   a_cross_copy: assert property (ce |=> cross_sel == $past(crossing_point_code))
      else $error("crossing code not passed");
   a_imped_copy: assert property (ce |=> imped_sel == $past(impedance_code))
      else $error("impedance code not passed");
   a_diff_gate: assert property (ce |=> diff_enable == (!$past(se_mode) && $past(buffer_supply_setting) != 3'h3 && $past(buffer_supply_setting) != 3'h4))
      else $error("differential enable wrong");
   a_se_copies: assert property ((se_mode && $past(se_mode) && $stable(comp_invert) && pad_oe) |-> complementary_pad == (true_pad ^ comp_invert))
      else $error("single-ended copies differ");
   a_pending_set: assert property ((ce && coarse_shift_write) |=> shift_pending)
      else $error("write not pending");
   a_applied_once: assert property (shift_applied |-> $past(shift_pending) ##1 !shift_applied)
      else $error("applied pulse wrong");
   a_min_high: assert property ((out_enable && $rose(true_pad)) |=> true_pad)
      else $error("high pulse below two periods");
   a_apply_bound: assert property ((shift_pending && out_enable) |-> ##[0:200] shift_applied)
      else $error("shift not applied in time");
endmodule // ocpa_stage_checker

bind ocpa_stage ocpa_stage_checker chk (.*);

// *** test/ocpa_rx_model.sv ***
// Receiver model: counts the high and low widths seen on the true pad.
`timescale 1ns/10ps
module ocpa_rx_model (
   // Clock and pad
   input wire logic mclk,
   input wire logic true_pad,
   // Measured widths and completed periods
   output int hi_len,
   output int lo_len,
   output int periods
);
   int cnt = 0;
   logic last = 1'b0;
   // Widths are counted in source periods, the unit in which the stage moves edges.
   always @(posedge mclk) begin
      cnt <= (true_pad === last) ? cnt + 1 : 1;
      last <= true_pad;
      if (last && !true_pad) begin
         hi_len <= cnt;
      end
      if (!last && true_pad) begin
         lo_len <= cnt;
         periods <= periods + 1;
      end
   end
endmodule // ocpa_rx_model

// *** test/ocpa_stage_test.sv ***
// Self-checking bench for the output coarse phase adjust stage.
`timescale 1ns/10ps
module ocpa_stage_test;
   import ocpa_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic oen = 1'b0, swr = 1'b0, se = 1'b0, inv = 1'b0, cen = 1'b1;
   logic [31:0] div = OCPA_RST_DIV, hcnt = 32'h0;
   logic signed [32:0] sval = 33'h0;
   logic [2:0] sup = 3'h0, xpt = 3'h0;
   logic [1:0] swg = 2'h0, imp = 2'h0;
   logic tp, cp, oe, dif, pend, appl;
   logic [1:0] swo, impo;
   logic [2:0] xo, supo;
   int hi_len, lo_len, periods;
   int error_cnt = 0;
   int checks_done = 0;

   ocpa_stage dut (.mclk(mclk), .rstn(rstn), .ce(cen), .divide_ratio(div),
      .high_count(hcnt), .out_enable(oen), .coarse_shift_value(sval),
      .coarse_shift_write(swr), .se_mode(se), .comp_invert(inv), .buffer_supply_setting(sup),
      .differential_swing_code(swg), .crossing_point_code(xpt), .impedance_code(imp),
      .true_pad(tp), .complementary_pad(cp), .pad_oe(oe), .swing_sel(swo), .cross_sel(xo),
      .imped_sel(impo), .supply_sel(supo), .diff_enable(dif), .shift_pending(pend),
      .shift_applied(appl));
   ocpa_rx_model rx (.mclk(mclk), .true_pad(tp), .hi_len(hi_len), .lo_len(lo_len),
      .periods(periods));

   initial begin
      forever #10 mclk = ~mclk;
   end

   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic wait_per();
      int n0;
      n0 = periods;
      for (int i = 0; i < 100 && periods == n0; i++) begin
         @(posedge mclk);
         #1;
      end
      if (periods == n0) begin
         chk(1'b0, "no output period seen");
      end
   endtask

   // Ratios stay at eight or more, so coarse shifts are legal.
   task automatic shift_case(input int d, input int h, input int s);
      int dh, dl, eh, el, hit;
      dh = (h == 0) ? d / 2 : h;
      dl = d - dh;
      eh = (h == 0) ? dh + (s >>> 1) : dh;
      el = dl + s - ((h == 0) ? (s >>> 1) : 0);
      eh = (eh < 2) ? 2 : eh;
      el = (el < 2) ? 2 : el;
      hit = 0;
      div = d;
      hcnt = h;
      repeat (3) wait_per();
      sval = s;
      swr = 1'b1;
      @(posedge mclk);
      #1;
      swr = 1'b0;
      for (int i = 0; i < 4 && hit == 0; i++) begin
         wait_per();
         hit = (hi_len == eh && lo_len == el);
      end
      chk(hit == 1, "shifted period not seen");
      wait_per();
      chk(hi_len == dh && lo_len == dl, "shift applied again");
   endtask

   task automatic buf_case();
      se = 1'b1;
      for (int c = 0; c < 8; c++) begin
         inv = c[2];
         swg = c[1:0];
         imp = ~c[1:0];
         xpt = c[2:0];
         sup = {1'b0, c[1:0]};
         repeat (2) @(posedge mclk);
         #1;
         chk(swo === swg && impo === imp && xo === xpt && supo === sup, "codes");
         chk(cp === (tp ^ inv) && dif === 1'b0 && oe === 1'b1, "single-ended pads");
      end
      se = 1'b0;
      sup = OCPA_SUPPLY_1V5;
      repeat (2) @(posedge mclk);
      #1;
      chk(dif === 1'b0, "differential at low supply");
      sup = OCPA_SUPPLY_3V3;
      repeat (2) @(posedge mclk);
      #1;
      chk(dif === 1'b1, "differential not enabled");
   endtask

   // Clock enable low must freeze pads, codes and requests; a write then is not taken.
   task automatic ce_case();
      logic tp0, cp0;
      logic [1:0] sw0;
      tp0 = tp;
      cp0 = cp;
      sw0 = swo;
      cen = 1'b0;
      swg = ~swo;
      sval = 33'sh4;
      swr = 1'b1;
      @(posedge mclk);
      #1;
      swr = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      chk(tp === tp0 && cp === cp0 && swo === sw0, "state moved with ce low");
      chk(pend === 1'b0, "write taken with ce low");
      cen = 1'b1;
      swg = sw0;
      repeat (2) @(posedge mclk);
      #1;
      chk(swo === swg && pend === 1'b0, "codes after ce");
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      #1;
      rstn = 1'b1;
      oen = 1'b1;
      shift_case(8, 0, 4);
      shift_case(8, 0, -3);
      shift_case(8, 0, -20);
      shift_case(9, 0, 5);
      shift_case(10, 3, 4);
      shift_case(10, 3, -9);
      buf_case();
      ce_case();
      print_verdict();
   end

   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
endmodule // ocpa_stage_test
